//--- inc/wd_pkg.sv
package wd_pkg;

   // ==========================================================
   // register indices: printed offsets are not all word aligned,
   // so each is an index and the byte address is four times it
   // ==========================================================
   localparam logic [31:0] WD_COUNT_INDEX   = 32'h5000_3100;
   localparam logic [31:0] WD_CONTROL_INDEX = 32'h5000_3102;
   localparam logic [31:0] WD_STATUS_INDEX  = 32'h5000_3104;

   // ==========================================================
   // decoded address width inside the block select
   // ==========================================================
   localparam int          DECODE_BITS      = 12;

   // ==========================================================
   // field layout
   // ==========================================================
   localparam int          UNLOCK_MSB       = 15;
   localparam int          UNLOCK_LSB       = 9;
   localparam int          COUNT_SIGN_BIT   = 8;
   localparam int          COUNT_MSB        = 8;
   localparam int          MODE_BIT         = 0;
   localparam int          STAT_FROZEN_BIT  = 0;
   localparam int          STAT_HALTED_BIT  = 1;
   localparam int          STAT_RUNNING_BIT = 2;
   localparam int          STAT_MODE_BIT    = 3;

   // ==========================================================
   // values
   // ==========================================================
   localparam logic [8:0]  COUNT_RESET      = 9'h0FF;
   localparam logic [8:0]  COUNT_RELOAD     = 9'h0FF;
   localparam logic [8:0]  COUNT_ZERO       = 9'h000;
   localparam logic [8:0]  COUNT_ONE        = 9'h001;
   localparam logic [8:0]  COUNT_LIMIT      = 9'h1F0;
   localparam logic [6:0]  UNLOCK_KEY       = 7'h00;
   localparam logic [31:0] READ_ZERO        = 32'h0000_0000;
   localparam logic [1:0]  HRESP_OKAY       = 2'h0;

   // ==========================================================
   // bus port states
   // ==========================================================
   typedef enum logic [2:0] {
      PORT_IDLE = 3'b001,
      PORT_WAIT = 3'b010,
      PORT_DONE = 3'b100
   } port_state_t;

   typedef struct packed {
      port_state_t                  phase;
      logic                         write;
      logic [DECODE_BITS-1:0]       addr;
      logic [31:0]                  rdata;
   } port_regs_t;

   typedef struct packed {
      logic [8:0] count;
      logic       direct_reset;
      logic       frozen;
      logic       nmi;
      logic       sys_reset;
   } wd_regs_t;

endpackage

//--- logic/wd_bus_port.sv
`timescale 1ns/1ns
// ==========================================================
// ahb-lite slave front end with one wait state per transfer
// ==========================================================
module wd_bus_port (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [1:0]       hresp,
   output logic [31:0]      hrdata,
   output logic [11:0]      access_addr,
   output logic             write_strobe,
   output logic [31:0]      write_data,
   input  wire logic [31:0] read_data
);

   wd_pkg::port_regs_t st;
   wd_pkg::port_regs_t next_st;
   logic               take;

   // ==========================================================
   // next state
   // ==========================================================
   always_comb begin
      next_st = st;
      take    = hsel && htrans[1] && hready;
      unique case (st.phase)
         wd_pkg::PORT_IDLE,
         wd_pkg::PORT_DONE: begin
            if (take) begin
               next_st.phase = wd_pkg::PORT_WAIT;
               next_st.write = hwrite;
               next_st.addr  = haddr[wd_pkg::DECODE_BITS-1:0];
            end else begin
               next_st.phase = wd_pkg::PORT_IDLE;
            end
         end
         wd_pkg::PORT_WAIT: begin
            // read data is sampled after any write of the previous transfer
            next_st.phase = wd_pkg::PORT_DONE;
            next_st.rdata = st.write ? wd_pkg::READ_ZERO : read_data;
         end
         default: begin
            next_st.phase = wd_pkg::PORT_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '{phase: wd_pkg::PORT_IDLE, write: 1'b0, addr: '0, rdata: '0};
      end else begin
         st <= next_st;
      end
   end

   assign hreadyout    = (st.phase != wd_pkg::PORT_WAIT);
   assign hresp        = wd_pkg::HRESP_OKAY;
   assign hrdata       = st.rdata;
   assign access_addr  = st.addr;
   assign write_strobe = (st.phase == wd_pkg::PORT_WAIT) && st.write;
   assign write_data   = hwdata;

endmodule

//--- logic/wd_timer.sv
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ns
module wd_timer (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [1:0]       hresp,
   output logic [31:0]      hrdata,
   input  wire logic        timebase_tick,
   input  wire logic        freeze_request,
   input  wire logic        resume_request,
   input  wire logic        debug_halted,
   input  wire logic        sw_reset_request,
   output logic             nmi_request,
   output logic             sys_reset_request
);

   wd_pkg::wd_regs_t st;
   wd_pkg::wd_regs_t next_st;
   logic [11:0]      access_addr;
   logic             write_strobe;
   logic [31:0]      write_data;
   logic [31:0]      read_data;
   logic             counting;
   logic [8:0]       decremented;

   // ==========================================================
   // helpers
   // ==========================================================
   function automatic logic reg_hit(input logic [11:0] addr, input logic [31:0] index);
      reg_hit = (addr == {index[9:0], 2'b00});
   endfunction

   function automatic logic at_or_below_zero(input logic [8:0] value);
      at_or_below_zero = value[wd_pkg::COUNT_SIGN_BIT] || (value == wd_pkg::COUNT_ZERO);
   endfunction

   // ==========================================================
   // register bus
   // ==========================================================
   wd_bus_port u_port (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .hsel         (hsel),
      .haddr        (haddr),
      .htrans       (htrans),
      .hwrite       (hwrite),
      .hwdata       (hwdata),
      .hready       (hready),
      .hreadyout    (hreadyout),
      .hresp        (hresp),
      .hrdata       (hrdata),
      .access_addr  (access_addr),
      .write_strobe (write_strobe),
      .write_data   (write_data),
      .read_data    (read_data)
   );

   // ==========================================================
   // read mux
   // ==========================================================
   always_comb begin
      read_data = wd_pkg::READ_ZERO;
      if (reg_hit(access_addr, wd_pkg::WD_COUNT_INDEX)) begin
         read_data[wd_pkg::COUNT_MSB:0] = st.count;
      end else if (reg_hit(access_addr, wd_pkg::WD_CONTROL_INDEX)) begin
         read_data[wd_pkg::MODE_BIT] = st.direct_reset;
      end else if (reg_hit(access_addr, wd_pkg::WD_STATUS_INDEX)) begin
         read_data[wd_pkg::STAT_FROZEN_BIT]  = st.frozen;
         read_data[wd_pkg::STAT_HALTED_BIT]  = debug_halted;
         read_data[wd_pkg::STAT_RUNNING_BIT] = counting;
         read_data[wd_pkg::STAT_MODE_BIT]    = st.direct_reset;
      end
   end

   // ==========================================================
   // counter and mode
   // ==========================================================
   always_comb begin
      next_st           = st;
      next_st.nmi       = 1'b0;
      next_st.sys_reset = 1'b0;
      // a freeze only holds the count in mode 0; debug halt holds it always
      counting    = !debug_halted && !(st.frozen && !st.direct_reset);
      decremented = st.count - wd_pkg::COUNT_ONE;

      if (!st.direct_reset) begin
         if (resume_request) begin
            next_st.frozen = 1'b0;
         end
         if (freeze_request) begin
            next_st.frozen = 1'b1;
         end
      end

      if (counting && timebase_tick) begin
         next_st.count = decremented;
         if (!st.direct_reset) begin
            if (decremented == wd_pkg::COUNT_ZERO) begin
               next_st.nmi = 1'b1;
            end
            if (decremented == wd_pkg::COUNT_LIMIT) begin
               next_st.sys_reset = 1'b1;
               next_st.count     = wd_pkg::COUNT_RELOAD;
            end
         end
      end

      // a bus reload wins over a tick's count and sys_reset in the same cycle, but not over its nmi
      if (write_strobe && reg_hit(access_addr, wd_pkg::WD_COUNT_INDEX) &&
          write_data[wd_pkg::UNLOCK_MSB:wd_pkg::UNLOCK_LSB] == wd_pkg::UNLOCK_KEY) begin
         next_st.count     = write_data[wd_pkg::COUNT_MSB:0];
         next_st.sys_reset = 1'b0;
      end
      if (write_strobe && reg_hit(access_addr, wd_pkg::WD_CONTROL_INDEX)) begin
         next_st.direct_reset = st.direct_reset | write_data[wd_pkg::MODE_BIT];
      end

      if (st.direct_reset && !debug_halted && at_or_below_zero(next_st.count)) begin
         next_st.sys_reset = 1'b1;
         next_st.count     = wd_pkg::COUNT_RELOAD;
      end

      // the watchdog's own reset and a software reset return the block to mode 0
      if (next_st.sys_reset || sw_reset_request) begin
         next_st.direct_reset = 1'b0;
         next_st.frozen       = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '{count: wd_pkg::COUNT_RESET, direct_reset: 1'b0, frozen: 1'b0,
                 nmi: 1'b0, sys_reset: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign nmi_request       = st.nmi;
   assign sys_reset_request = st.sys_reset;

endmodule

//--- testbench/wd_timer_properties.sv
`timescale 1ns/1ns
// ==========================================================
// watchdog port properties
// ==========================================================
module wd_timer_properties (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hready,
   input wire logic       hreadyout,
   input wire logic [1:0] hresp,
   input wire logic       timebase_tick,
   input wire logic       debug_halted,
   input wire logic       nmi_request,
   input wire logic       sys_reset_request
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_NMI_PULSE: assert property (nmi_request |=> !nmi_request)
      else $error("nmi request longer than one cycle");
   AST_RST_PULSE: assert property (sys_reset_request |=> !sys_reset_request)
      else $error("reset request longer than one cycle");
   AST_NMI_TICK: assert property (nmi_request |-> $past(timebase_tick))
      else $error("nmi request without a timebase tick");
   AST_HALT_NMI: assert property (nmi_request |-> !$past(debug_halted))
      else $error("nmi request while halted");
   AST_HALT_RST: assert property (sys_reset_request |-> !$past(debug_halted))
      else $error("reset request while halted");
   AST_APART: assert property (!(nmi_request && sys_reset_request))
      else $error("nmi and reset requested together");
   AST_RELOAD: assert property (sys_reset_request |=> !nmi_request)
      else $error("nmi right after reload");
   AST_WAIT: assert property ((hsel && htrans[1] && hready) |=> !hreadyout ##1 hreadyout)
      else $error("transfer without exactly one wait state");
   AST_OKAY: assert property (hresp == 2'h0)
      else $error("response not okay");
   cover property (nmi_request);
   cover property (sys_reset_request);
   cover property (debug_halted && timebase_tick);
endmodule

//--- testbench/signed_watchdog_timer_tb_top.sv
`timescale 1ns/1ns
module signed_watchdog_timer_tb_top;
   localparam logic [31:0] cnt_a = {wd_pkg::WD_COUNT_INDEX[29:0], 2'b00};
   localparam logic [31:0] ctl_a = {wd_pkg::WD_CONTROL_INDEX[29:0], 2'b00};
   localparam logic [31:0] sts_a = {wd_pkg::WD_STATUS_INDEX[29:0], 2'b00};
   logic        hclk = 1'b0;
   logic        hresetn, hsel, hwrite, hready, hreadyout;
   logic        timebase_tick, freeze_request, resume_request;
   logic        debug_halted, sw_reset_request, nmi_request, sys_reset_request;
   logic [1:0]  htrans, hresp;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   int          n_fail, tests_run, n_nmi, n_rst, cyc, b0, b1;
   assign hready = hreadyout;
   wd_timer dut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hreadyout, .hresp, .hrdata, .timebase_tick, .freeze_request, .resume_request,
      .debug_halted, .sw_reset_request, .nmi_request, .sys_reset_request
   );
   always #20 hclk = ~hclk;
   // ==========================================================
   // event counters and hang guard
   // ==========================================================
   always @(posedge hclk) begin
      n_nmi += nmi_request;
      n_rst += sys_reset_request;
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("mismatches %0d checks %0d", n_fail, tests_run);
      if (n_fail == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      // address phase stands until hready is seen high at a rising edge
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      // data phase stands until hready is seen high again; read data taken there
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         timebase_tick <= 1'b1;
         @(posedge hclk);
         timebase_tick <= 1'b0;
         @(posedge hclk);
      end
   endtask
   // one-cycle pulse: 0 freeze, 1 resume, 2 software reset
   task automatic pulse(input int k);
      freeze_request <= (k == 0);
      resume_request <= (k == 1);
      sw_reset_request <= (k == 2);
      @(posedge hclk);
      {freeze_request, resume_request, sw_reset_request} <= 3'b000;
      @(posedge hclk);
   endtask
   task automatic t_reset();
      rchk(cnt_a, 32'h0000_00FF);
      rchk(ctl_a, 32'h0000_0000);
      rchk(32'h4000_C800, 32'h0000_0000);
   endtask
   task automatic t_unlock();
      xfer(1'b1, cnt_a, 32'h0000_0205);
      rchk(cnt_a, 32'h0000_00FF);
      xfer(1'b1, cnt_a, 32'h0000_0003);
      rchk(cnt_a, 32'h0000_0003);
   endtask
   task automatic t_nmi_wrap();
      b0 = n_nmi;
      b1 = n_rst;
      tick(3);
      rchk(cnt_a, 32'h0000_0000);
      chk(n_nmi - b0, 32'h0000_0001);
      tick(1);
      rchk(cnt_a, 32'h0000_01FF);
      xfer(1'b1, cnt_a, 32'h0000_01F1);
      tick(1);
      rchk(cnt_a, 32'h0000_00FF);
      chk(n_rst - b1, 32'h0000_0001);
   endtask
   task automatic t_freeze();
      pulse(0);
      tick(2);
      rchk(cnt_a, 32'h0000_00FF);
      rchk(sts_a, 32'h0000_0001);
      pulse(1);
      tick(1);
      rchk(cnt_a, 32'h0000_00FE);
      debug_halted <= 1'b1;
      tick(2);
      rchk(cnt_a, 32'h0000_00FE);
      rchk(sts_a, 32'h0000_0002);
      debug_halted <= 1'b0;
      repeat (5) @(posedge hclk);
      rchk(cnt_a, 32'h0000_00FE);
   endtask
   task automatic t_mode1();
      xfer(1'b1, ctl_a, 32'h0000_0001);
      rchk(ctl_a, 32'h0000_0001);
      xfer(1'b1, ctl_a, 32'h0000_0000);
      rchk(ctl_a, 32'h0000_0001);
      pulse(0);
      tick(1);
      rchk(cnt_a, 32'h0000_00FD);
      rchk(sts_a, 32'h0000_000C);
      xfer(1'b1, cnt_a, 32'h0000_0001);
      b0 = n_nmi;
      b1 = n_rst;
      tick(1);
      rchk(cnt_a, 32'h0000_00FF);
      chk(n_rst - b1, 32'h0000_0001);
      chk(n_nmi - b0, 32'h0000_0000);
      rchk(ctl_a, 32'h0000_0000);
      xfer(1'b1, ctl_a, 32'h0000_0001);
      pulse(2);
      rchk(ctl_a, 32'h0000_0000);
   endtask
   initial begin
      {hresetn, hwrite, htrans, haddr, hwdata, timebase_tick} <= '0;
      {freeze_request, resume_request, debug_halted, sw_reset_request} <= 4'h0;
      hsel <= 1'b1;
      hsize <= 3'b010;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_unlock();
      t_nmi_wrap();
      t_freeze();
      t_mode1();
      finish_test();
   end
endmodule
bind wd_timer wd_timer_properties chk (.hclk, .hresetn, .hsel, .htrans, .hready, .hreadyout,
   .hresp, .timebase_tick, .debug_halted, .nmi_request, .sys_reset_request);
